// ==== rtl/smc_pkg.sv ====
package smc_pkg;

   // Word layout: kind code above a 24-bit payload
   localparam int KIND_W  = 8;
   localparam int PAY_W   = 24;
   localparam int WORD_W  = KIND_W + PAY_W;
   localparam int WIDE_W  = 32;        // Internal width after sign extension
   localparam int TICK_W  = 23;        // Unsigned tick count bits 0..22
   localparam int DIR_BIT = 23;        // Direction bit, 1 = backward
   localparam int SIGN_BIT = PAY_W - 1;

   // Measurement kind codes
   localparam logic [KIND_W-1:0] KIND_NONE       = 8'h00;
   localparam logic [KIND_W-1:0] KIND_GYRO_Z     = 8'h05;
   localparam logic [KIND_W-1:0] KIND_WHEEL_RL   = 8'h08;
   localparam logic [KIND_W-1:0] KIND_WHEEL_RR   = 8'h09;
   localparam logic [KIND_W-1:0] KIND_SPEED_TICK = 8'h0a;
   localparam logic [KIND_W-1:0] KIND_SPEED      = 8'h0b;
   localparam logic [KIND_W-1:0] KIND_GYRO_TEMP  = 8'h0c;
   localparam logic [KIND_W-1:0] KIND_GYRO_Y     = 8'h0d;
   localparam logic [KIND_W-1:0] KIND_GYRO_X     = 8'h0e;
   localparam logic [KIND_W-1:0] KIND_ACC_X      = 8'h10;
   localparam logic [KIND_W-1:0] KIND_ACC_Y      = 8'h11;
   localparam logic [KIND_W-1:0] KIND_ACC_Z      = 8'h12;

   // Raw sample set: acc x,y,z, gyro x,y,z, temperature
   localparam int            RAW_COUNT = 7;
   localparam int            RAW_IDX_W = 3;
   localparam logic [RAW_IDX_W-1:0] RAW_LAST_IDX = 3'h6;
   localparam int            TICK_SRC  = 3;  // Rear-left, rear-right, single
   localparam int            AXES      = 6;  // Compensated rate x,y,z, accel x,y,z
   localparam int            ANGLES    = 3;  // Roll, pitch, heading

   // Two-entry output buffer
   localparam int BUF_DEPTH = 2;
   localparam int BUF_CNT_W = 2;

   // Host register map (APB, byte addresses)
   localparam int              APB_AW    = 12;
   localparam logic [APB_AW-1:0] REG_TX   = 12'h000;
   localparam logic [APB_AW-1:0] REG_RX   = 12'h004;
   localparam logic [APB_AW-1:0] REG_STAT = 12'h008;
   localparam logic [APB_AW-1:0] REG_RXSX = 12'h00c;
   localparam int STAT_RX_FULL = 0;
   localparam int STAT_RX_LAST = 1;
   localparam int STAT_TX_BUSY = 2;
   localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [0:0] {
      RAW_IDLE = 1'b0,
      RAW_SEND = 1'b1
   } smc_raw_state_type;

   // Kind code of each raw slot
   function automatic logic [KIND_W-1:0] raw_kind(input logic [RAW_IDX_W-1:0] idx);
      case (idx)
         3'h0:    raw_kind = KIND_ACC_X;
         3'h1:    raw_kind = KIND_ACC_Y;
         3'h2:    raw_kind = KIND_ACC_Z;
         3'h3:    raw_kind = KIND_GYRO_X;
         3'h4:    raw_kind = KIND_GYRO_Y;
         3'h5:    raw_kind = KIND_GYRO_Z;
         3'h6:    raw_kind = KIND_GYRO_TEMP;
         default: raw_kind = KIND_NONE;
      endcase
   endfunction : raw_kind

   // Two's complement widening of a payload
   function automatic logic [WIDE_W-1:0] sign_extend(input logic [PAY_W-1:0] p);
      sign_extend = {{(WIDE_W - PAY_W){p[SIGN_BIT]}}, p};
   endfunction : sign_extend

endpackage : smc_pkg

// ==== rtl/smc_link_if.sv ====
`timescale 1ns/1ps
// Measurement word link: up = device to host, dn = host to device
interface smc_link_if (
   input wire logic ref_clk,
   input wire logic reset_n
);
   logic [smc_pkg::WORD_W-1:0] up_word;   // Device word out
   logic                       up_valid;
   logic                       up_ready;
   logic                       up_last;   // Last word of a raw message
   logic [smc_pkg::WORD_W-1:0] dn_word;   // Host word in
   logic                       dn_valid;
   logic                       dn_ready;

   modport dev  (input ref_clk, reset_n, up_ready, dn_word, dn_valid,
                 output up_word, up_valid, up_last, dn_ready);
   modport host (input ref_clk, reset_n, up_word, up_valid, up_last, dn_ready,
                 output up_ready, dn_word, dn_valid);
endinterface : smc_link_if

// ==== rtl/smc_dev.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Word is kind code plus 24-bit payload
// - Tick payload: count bits 0-22, direction 23
// - Codes 8, 9, 10 mark tick sources
// - Fixed codes for gyro, accel, speed, temperature
// - Link carries samples out, ticks in
// - Each word decoded by its code alone
// - Raw message holds one sample per kind
// - Nonzero rate setting emits at sampling rate
// - Raw output only with directly attached sensors
// - Fusion keeps consuming samples during raw output
// - Dynamics report only compensated axes
// - Attitude angles each carry accuracy estimate
module smc_dev (
   smc_link_if.dev                                                  link,
   input  wire logic                                                ref_clk,
   input  wire logic                                                reset_n,
   input  wire logic [7:0]                                          raw_rate_setting,
   input  wire logic                                                imu_direct,
   input  wire logic                                                sample_strobe,
   input  wire logic [smc_pkg::RAW_COUNT-1:0][smc_pkg::PAY_W-1:0]  imu_sample,
   output logic                                                     fusion_strobe_q,
   output logic [smc_pkg::RAW_COUNT-1:0][smc_pkg::PAY_W-1:0]       fusion_sample_q,
   output logic                                                     raw_active,
   output logic                                                     raw_overrun_q,
   output logic [smc_pkg::TICK_SRC-1:0][smc_pkg::TICK_W-1:0]       tick_count_q,
   output logic [smc_pkg::TICK_SRC-1:0]                             tick_backward_q,
   output logic [smc_pkg::TICK_SRC-1:0]                             tick_strobe_q,
   output logic [smc_pkg::WIDE_W-1:0]                               speed_q,
   output logic                                                     speed_strobe_q,
   input  wire logic                                                dyn_strobe,
   input  wire logic [smc_pkg::AXES-1:0]                            dyn_comp_mask,
   input  wire logic [smc_pkg::AXES-1:0][smc_pkg::PAY_W-1:0]        dyn_value,
   output logic [smc_pkg::AXES-1:0]                                 dyn_avail_q,
   output logic [smc_pkg::AXES-1:0][smc_pkg::PAY_W-1:0]             dyn_value_q,
   input  wire logic                                                att_strobe,
   input  wire logic [smc_pkg::ANGLES-1:0][smc_pkg::PAY_W-1:0]      att_angle,
   input  wire logic [smc_pkg::ANGLES-1:0][smc_pkg::PAY_W-1:0]      att_accuracy,
   output logic                                                     att_valid_q,
   output logic [smc_pkg::ANGLES-1:0][smc_pkg::PAY_W-1:0]           att_angle_q,
   output logic [smc_pkg::ANGLES-1:0][smc_pkg::PAY_W-1:0]           att_accuracy_q
);

   smc_pkg::smc_raw_state_type           state_q;      // Raw sequencer state
   logic [smc_pkg::RAW_IDX_W-1:0]        idx_q;        // Slot being queued
   logic [smc_pkg::RAW_COUNT-1:0][smc_pkg::PAY_W-1:0] snap_q; // Frozen sample set
   logic                                 raw_enable;   // Gate for raw output
   logic                                 push;         // Word enters buffer
   logic                                 pop;          // Word leaves buffer
   logic                                 buf_ready;    // Buffer has a free slot
   logic [smc_pkg::WORD_W-1:0]           push_word;
   logic                                 push_last;
   logic [smc_pkg::BUF_DEPTH-1:0][smc_pkg::WORD_W-1:0] buf_word_q; // Buffer storage
   logic [smc_pkg::BUF_DEPTH-1:0]        buf_last_q;
   logic                                 wr_ptr_q;     // Write slot index
   logic                                 rd_ptr_q;     // Read slot index
   logic [smc_pkg::BUF_CNT_W-1:0]        count_q;      // Words held
   logic [smc_pkg::KIND_W-1:0]           dn_kind;      // Inbound code
   logic [smc_pkg::PAY_W-1:0]            dn_pay;       // Inbound payload

   // Raw output needs a nonzero rate and direct-wired sensors
   assign raw_enable = (raw_rate_setting != 8'h00) && imu_direct;
   assign raw_active = (state_q == smc_pkg::RAW_SEND);

   // Fusion copy runs whatever the raw setting is
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fusion_strobe_q <= 1'b0;
         fusion_sample_q <= '0;
      end else begin
         fusion_strobe_q <= sample_strobe;
         if (sample_strobe) begin
            fusion_sample_q <= imu_sample;
         end
      end
   end

   // Raw sequencer: snapshot, then queue one word per kind
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q       <= smc_pkg::RAW_IDLE;
         idx_q         <= '0;
         snap_q        <= '0;
         raw_overrun_q <= 1'b0;
      end else begin
         raw_overrun_q <= 1'b0;
         case (state_q)
            smc_pkg::RAW_IDLE: begin
               if (sample_strobe && raw_enable) begin
                  snap_q  <= imu_sample;
                  idx_q   <= '0;
                  state_q <= smc_pkg::RAW_SEND;
               end
            end
            smc_pkg::RAW_SEND: begin
               // A sample during a stalled message is skipped, not mixed in
               if (sample_strobe) begin
                  raw_overrun_q <= 1'b1;
               end
               if (push) begin
                  if (idx_q == smc_pkg::RAW_LAST_IDX) begin
                     state_q <= smc_pkg::RAW_IDLE;
                  end else begin
                     idx_q <= idx_q + 3'h1;
                  end
               end
            end
            default: begin
               state_q <= smc_pkg::RAW_IDLE;
            end
         endcase
      end
   end

   // Each slot tagged with its own kind code
   assign push_word = {smc_pkg::raw_kind(idx_q), snap_q[idx_q]};
   assign push_last = (idx_q == smc_pkg::RAW_LAST_IDX);
   assign push      = raw_active && buf_ready;
   assign pop       = link.up_valid && link.up_ready;
   assign buf_ready = (count_q != 2'h2);

   // Buffer storage, one entry per slot
   generate
      for (genvar e = 0; e < smc_pkg::BUF_DEPTH; e++) begin : g_buf
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               buf_word_q[e] <= smc_pkg::WORD_RESET;
               buf_last_q[e] <= 1'b0;
            end else if (push && (wr_ptr_q == 1'(e))) begin
               buf_word_q[e] <= push_word;
               buf_last_q[e] <= push_last;
            end
         end
      end
   endgenerate

   // Buffer pointers; a host stall backs up into the sequencer
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         case ({push, pop})
            2'b10:   count_q <= count_q + 2'h1;
            2'b01:   count_q <= count_q - 2'h1;
            default: count_q <= count_q;
         endcase
      end
   end

   // Outbound side of the link
   assign link.up_valid = (count_q != 2'h0);
   assign link.up_word  = buf_word_q[rd_ptr_q];
   assign link.up_last  = buf_last_q[rd_ptr_q];

   // Inbound words are always accepted
   assign link.dn_ready = 1'b1;
   assign dn_kind = link.dn_word[smc_pkg::WORD_W-1:smc_pkg::PAY_W];
   assign dn_pay  = link.dn_word[smc_pkg::PAY_W-1:0];

   // Inbound decode by code; empty and unknown codes are dropped
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_count_q    <= '0;
         tick_backward_q <= '0;
         tick_strobe_q   <= '0;
         speed_q         <= '0;
         speed_strobe_q  <= 1'b0;
      end else begin
         tick_strobe_q  <= '0;
         speed_strobe_q <= 1'b0;
         if (link.dn_valid) begin
            case (dn_kind)
               smc_pkg::KIND_WHEEL_RL, smc_pkg::KIND_WHEEL_RR,
               smc_pkg::KIND_SPEED_TICK: begin
                  // Codes 8..10 map to slots 0..2
                  tick_count_q[dn_kind[1:0]]    <= dn_pay[smc_pkg::TICK_W-1:0];
                  tick_backward_q[dn_kind[1:0]] <= dn_pay[smc_pkg::DIR_BIT];
                  tick_strobe_q[dn_kind[1:0]]   <= 1'b1;
               end
               smc_pkg::KIND_SPEED: begin
                  speed_q        <= smc_pkg::sign_extend(dn_pay);
                  speed_strobe_q <= 1'b1;
               end
               default: begin
                  // Code zero carries nothing
                  speed_strobe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Dynamics: uncompensated axes shown unavailable and zeroed
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dyn_avail_q <= '0;
         dyn_value_q <= '0;
      end else if (dyn_strobe) begin
         dyn_avail_q <= dyn_comp_mask;
         for (int a = 0; a < smc_pkg::AXES; a++) begin
            dyn_value_q[a] <= dyn_comp_mask[a] ? dyn_value[a] : '0;
         end
      end
   end

   // Attitude: angles and accuracies latched together
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         att_valid_q    <= 1'b0;
         att_angle_q    <= '0;
         att_accuracy_q <= '0;
      end else begin
         att_valid_q <= att_strobe;
         if (att_strobe) begin
            att_angle_q    <= att_angle;
            att_accuracy_q <= att_accuracy;
         end
      end
   end

endmodule : smc_dev

// ==== rtl/smc_host.sv ====
`timescale 1ns/1ps
// Host end: APB registers front the measurement link
module smc_host (
   smc_link_if.host                    link,
   input  wire logic                   ref_clk,
   input  wire logic                   reset_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [smc_pkg::APB_AW-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr
);

   logic [smc_pkg::WORD_W-1:0] tx_word_q;   // Word offered to the device
   logic                       tx_valid_q;  // Word pending on the link
   logic [smc_pkg::WORD_W-1:0] rx_word_q;   // Last word from the device
   logic                       rx_last_q;
   logic                       rx_full_q;   // Unread word held
   logic                       access;      // APB access phase
   logic                       tx_hit;
   logic                       rx_hit;
   logic                       mapped;

   assign access = psel && penable;
   assign tx_hit = (paddr == smc_pkg::REG_TX);
   assign rx_hit = (paddr == smc_pkg::REG_RX);
   assign mapped = tx_hit || rx_hit || (paddr == smc_pkg::REG_STAT)
                   || (paddr == smc_pkg::REG_RXSX);
   // Writes to TX wait while a word is still pending
   assign pready  = !(pwrite && tx_hit && tx_valid_q);
   assign pslverr = access && !mapped;

   // Read mux; unmapped reads give zero
   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == smc_pkg::REG_RX) begin
         prdata = rx_word_q;
      end else if (paddr == smc_pkg::REG_STAT) begin
         prdata[smc_pkg::STAT_RX_FULL] = rx_full_q;
         prdata[smc_pkg::STAT_RX_LAST] = rx_last_q;
         prdata[smc_pkg::STAT_TX_BUSY] = tx_valid_q;
      end else if (paddr == smc_pkg::REG_RXSX) begin
         prdata = smc_pkg::sign_extend(rx_word_q[smc_pkg::PAY_W-1:0]);
      end
   end

   // Outbound word: software writes code and payload as one word
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_word_q  <= smc_pkg::WORD_RESET;
         tx_valid_q <= 1'b0;
      end else if (access && pwrite && tx_hit && !tx_valid_q) begin
         tx_word_q  <= pwdata;
         tx_valid_q <= 1'b1;
      end else if (tx_valid_q && link.dn_ready) begin
         tx_valid_q <= 1'b0;
      end
   end

   assign link.dn_word  = tx_word_q;
   assign link.dn_valid = tx_valid_q;

   // Inbound word: held until software reads RX
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_word_q <= smc_pkg::WORD_RESET;
         rx_last_q <= 1'b0;
         rx_full_q <= 1'b0;
      end else if (link.up_valid && link.up_ready) begin
         rx_word_q <= link.up_word;
         rx_last_q <= link.up_last;
         rx_full_q <= 1'b1;
      end else if (access && !pwrite && rx_hit) begin
         rx_full_q <= 1'b0;
      end
   end

   // Stall the device while a word is unread
   assign link.up_ready = !rx_full_q;

endmodule : smc_host

// ==== test/smc_link_assertions.sv ====
`timescale 1ns/1ps
// Watches both directions of the measurement link
module smc_link_assertions (
   input wire logic                       ref_clk,
   input wire logic                       reset_n,
   input wire logic [smc_pkg::WORD_W-1:0] up_word,
   input wire logic                       up_valid,
   input wire logic                       up_ready,
   input wire logic                       up_last,
   input wire logic [smc_pkg::WORD_W-1:0] dn_word,
   input wire logic                       dn_valid,
   input wire logic                       dn_ready
);
   logic [7:0] kind;   // Kind field of the offered word
   logic [7:0] prev_q; // Kind of the last word taken
   logic [7:0] want;   // Kind the raw order expects next
   assign kind = up_word[31:24];

   // Remember what was accepted last
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_q <= 8'h00;
      end else if (up_valid && up_ready) begin
         prev_q <= kind;
      end
   end

   // Raw order; anything else restarts at accel x
   always_comb begin
      case (prev_q)
         8'h10:   want = 8'h11;
         8'h11:   want = 8'h12;
         8'h12:   want = 8'h0e;
         8'h0e:   want = 8'h0d;
         8'h0d:   want = 8'h05;
         8'h05:   want = 8'h0c;
         default: want = 8'h10;
      endcase
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence take_s;
      up_valid && up_ready;
   endsequence
   sequence stall_s;
      up_valid && !up_ready;
   endsequence

   up_hold_a: assert property (stall_s |=> up_valid && $stable(up_word))
      else $error("stalled word changed");
   raw_order_a: assert property (up_valid |-> kind == want)
      else $error("raw word out of order");
   last_tag_a: assert property (up_valid |-> up_last == (kind == 8'h0c))
      else $error("last flag on wrong word");
   one_word_a: assert property (take_s |=> !up_ready)
      else $error("host took a second word unread");
   no_empty_a: assert property (up_valid |-> kind != 8'h00)
      else $error("empty kind sent");
   dn_ready_a: assert property (dn_ready)
      else $error("device refused a word");
   dn_once_a: assert property (dn_valid |=> !dn_valid)
      else $error("host word offered twice");
   reset_idle_a: assert property ($rose(reset_n) |-> !up_valid && !dn_valid)
      else $error("link busy after reset");
endmodule : smc_link_assertions

// ==== test/sensor_measurement_codec_tb.sv ====
`timescale 1ns/1ps
// Host and device ends joined by the link
module sensor_measurement_codec_tb;
   localparam int N = smc_pkg::RAW_COUNT;
   // Raw slot kinds, index 0 first on the wire
   localparam logic [6:0][7:0] KINDS = {8'h0c, 8'h05, 8'h0d, 8'h0e, 8'h12, 8'h11, 8'h10};
   logic               ref_clk, reset_n;
   logic               psel, penable, pwrite, pready, pslverr;
   logic [11:0]        paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic               e;
   logic [7:0]         rate, code;     // Rate setting, downlink kind
   logic [23:0]        pay;            // Downlink payload
   logic               direct, strobe, dyn_stb, att_stb;
   logic [N-1:0][23:0] sample, raw_exp, fus_smp;
   logic [5:0]         mask, avail;
   logic [5:0][23:0]   dval, dq;
   logic [2:0][23:0]   ang, acc, angq, accq;
   logic               fus_stb, overrun, raw_act, spd_stb, att_v;
   logic [2:0][22:0]   tcnt;
   logic [2:0]         tback, tstb;
   logic [31:0]        spd;
   int                 errors, compares, cycles, seed;

   smc_link_if link (.ref_clk(ref_clk), .reset_n(reset_n));
   smc_dev smc_dev_inst (.link(link), .ref_clk(ref_clk), .reset_n(reset_n),
      .raw_rate_setting(rate), .imu_direct(direct), .sample_strobe(strobe),
      .imu_sample(sample), .fusion_strobe_q(fus_stb), .fusion_sample_q(fus_smp),
      .raw_active(raw_act), .raw_overrun_q(overrun), .tick_count_q(tcnt),
      .tick_backward_q(tback), .tick_strobe_q(tstb), .speed_q(spd),
      .speed_strobe_q(spd_stb), .dyn_strobe(dyn_stb), .dyn_comp_mask(mask),
      .dyn_value(dval), .dyn_avail_q(avail), .dyn_value_q(dq), .att_strobe(att_stb),
      .att_angle(ang), .att_accuracy(acc), .att_valid_q(att_v), .att_angle_q(angq),
      .att_accuracy_q(accq));
   smc_host smc_host_inst (.link(link), .ref_clk(ref_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   smc_link_assertions smc_link_assertions_inst (.ref_clk(ref_clk), .reset_n(reset_n),
      .up_word(link.up_word), .up_valid(link.up_valid), .up_ready(link.up_ready),
      .up_last(link.up_last), .dn_word(link.dn_word), .dn_valid(link.dn_valid),
      .dn_ready(link.dn_ready));

   // Free running clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Hang guard, far above the few hundred cycles needed
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end

   // Two's complement widening, worked out here
   function automatic logic [31:0] sext(input logic [23:0] p);
      return {{8{p[23]}}, p};
   endfunction : sext

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; waits for pready without assuming a count
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Only the hang guard ends a wait for pready
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Sample strobe; fusion sees every set one cycle later
   task automatic pulse();
      @(posedge ref_clk);
      strobe <= 1'b1;
      @(posedge ref_clk);
      strobe <= 1'b0;
      @(negedge ref_clk);
      chk(fus_stb, 1);
      for (int i = 0; i < N; i++) chk(fus_smp[i], sample[i]);
   endtask : pulse

   // Drain one raw message through the host registers
   task automatic read_raw();
      logic [31:0] st, sx;
      int n;
      for (int i = 0; i < N; i++) begin
         st = 32'h0;
         n = 0;
         while (st[0] !== 1'b1 && n < 40) begin
            apb(1'b0, smc_pkg::REG_STAT, 32'h0);
            st = rd;
            n++;
         end
         chk(st[1], i == N - 1);
         apb(1'b0, smc_pkg::REG_RXSX, 32'h0);
         sx = rd;
         apb(1'b0, smc_pkg::REG_RX, 32'h0);
         chk(rd, {KINDS[i], raw_exp[i]});
         chk(sx, sext(raw_exp[i]));
      end
   endtask : read_raw

   task automatic end_of_test();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      seed = 80;
      {psel, penable, pwrite, paddr, pwdata, strobe, dyn_stb, att_stb} = '0;
      {sample, mask, dval, ang, acc} = '0;
      rate = 8'h01;
      direct = 1'b1;
      reset_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Raw messages, second strobe lands while the host stalls
      for (int m = 0; m < 2; m++) begin
         @(posedge ref_clk);
         for (int i = 0; i < N; i++) sample[i] <= 24'($random(seed));
         if (m == 0) sample[3] <= 24'h800000;
         rate <= 8'($random(seed)) | 8'h01;
         @(posedge ref_clk);
         raw_exp = sample;
         pulse();
         @(posedge ref_clk);
         for (int i = 0; i < N; i++) sample[i] <= 24'($random(seed));
         @(posedge ref_clk);
         pulse();
         chk(overrun, 1);
         read_raw();
         repeat (3) @(negedge ref_clk);
         chk(raw_act, 0);
      end
      // Raw output barred: sensors not direct, then rate zero
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         rate <= (k == 0) ? 8'h05 : 8'h00;
         direct <= (k == 1);
         pulse();
         chk(raw_act, 0);
         repeat (10) @(negedge ref_clk);
         chk(link.up_valid, 0);
      end
      // Downlink words: ticks, speed, empty and reserved kinds
      for (int k = 0; k < 12; k++) begin
         code = (k < 9) ? 8'(8 + k % 3) : ((k == 9) ? 8'h0b : ((k == 10) ? 8'h00 : 8'h0f));
         pay = (k == 3) ? 24'hffffff : 24'($random(seed));
         if (k == 9) pay[23] = 1'b1;
         apb(1'b1, smc_pkg::REG_TX, {code, pay});
         chk(e, 0);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(tstb, (k < 9) ? (1 << (k % 3)) : 0);
         chk(spd_stb, k == 9);
         if (k < 9) chk(tcnt[k % 3], pay[22:0]);
         if (k < 9) chk(tback[k % 3], pay[23]);
         if (k == 9) chk(spd, sext(pay));
      end
      // Unmapped place answers with an error and zero
      apb(1'b0, 12'h010, 32'h0);
      chk(e, 1);
      chk(rd, 32'h0);
      // Dynamics mask corners and attitude with accuracy
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         mask <= (k == 0) ? 6'h3f : ((k == 1) ? 6'h00 : 6'($random(seed)));
         for (int i = 0; i < 6; i++) dval[i] <= 24'($random(seed));
         for (int i = 0; i < 3; i++) ang[i] <= 24'($random(seed));
         for (int i = 0; i < 3; i++) acc[i] <= 24'($random(seed));
         dyn_stb <= 1'b1;
         att_stb <= 1'b1;
         @(posedge ref_clk);
         dyn_stb <= 1'b0;
         att_stb <= 1'b0;
         @(negedge ref_clk);
         chk(avail, mask);
         chk(att_v, 1);
         for (int i = 0; i < 6; i++) chk(dq[i], mask[i] ? dval[i] : 24'h0);
         for (int i = 0; i < 3; i++) chk(angq[i], ang[i]);
         for (int i = 0; i < 3; i++) chk(accq[i], acc[i]);
      end
      end_of_test();
   end
endmodule : sensor_measurement_codec_tb
